// file: hdl/paged_reg_pkg.sv
// Shared constants for the paged register bank and its AHB-Lite controller
package paged_reg_pkg;
    // Link field widths
    localparam int PAGE_W = 8;
    localparam int OFF_W = 8;
    localparam int DATA_W = 8;
    // Offsets present on every page
    localparam logic [7:0] OFF_PAGE = 8'h01;
    localparam logic [7:0] OFF_READY = 8'hfe;
    // Offsets on page 0
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_STICKY = 8'h11;
    localparam logic [7:0] OFF_BURN = 8'he3;
    localparam int BURN_BIT = 0;
    // Implemented pages
    localparam logic [7:0] PAGE_ALARM = 8'h00;
    localparam logic [7:0] PAGE_OUTPUT = 8'h01;
    localparam logic [7:0] PAGE_DIVIDER = 8'h02;
    localparam logic [7:0] PAGE_NDIV = 8'h03;
    localparam logic [7:0] PAGE_CTRLIO = 8'h09;
    localparam int NUM_PAGES = 5;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    // Readiness codes
    localparam logic [7:0] READY_YES = 8'h0f;
    localparam logic [7:0] READY_NO = 8'h00;
    // Status and sticky flag layout, bit 4 unused
    localparam int FLAG_W = 6;
    localparam logic [5:0] FLAG_MASK = 6'h2f;
    // Configuration registers mirrored onto device pins
    localparam logic [15:0] ADDR_OUT_EN = 16'h0102;
    localparam logic [15:0] ADDR_REF_CFG = 16'h0943;
    localparam logic [7:0] OUT_EN_BASE = 8'h00;
    localparam logic [7:0] REF_CFG_BASE = 8'h03;
    localparam int REF_XTAL48_BIT = 0;
    localparam int REF_IO18_BIT = 1;
    // Controller registers, byte addresses on AHB-Lite
    localparam logic [7:0] HREG_ADDR = 8'h00;
    localparam logic [7:0] HREG_WDATA = 8'h04;
    localparam logic [7:0] HREG_CTRL = 8'h08;
    localparam logic [7:0] HREG_RDATA = 8'h0c;
    localparam logic [7:0] HREG_IRQ_STATUS = 8'h10;
    localparam logic [7:0] HREG_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] HREG_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] HREG_PAGE = 8'h1c;
    localparam int CTRL_GO = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_RMW = 2;
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REFUSED = 1;
    localparam int RDATA_ERR_BIT = 8;
endpackage

// file: hdl/reg_link_if.sv
// Byte-wide request/acknowledge link between host controller and register bank
`timescale 1ns/1ps
`default_nettype none
interface reg_link_if (
    input wire logic clk,
    input wire logic rst
);
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;

    modport host (
        output req,
        output wr,
        output addr,
        output wdata,
        input rdata,
        input ack
    );

    modport device (
        input req,
        input wr,
        input addr,
        input wdata,
        output rdata,
        output ack
    );
endinterface
`default_nettype wire

// file: hdl/paged_reg_bank.sv
// Paged byte-wide register bank with nonvolatile defaults, device end of the link
// Function
// (RL1) Pages of up to 256 byte-wide registers
// (RL2) Writing offset 0x01 selects the active page
// (RL3) Full address is page byte then offset
// (RL4) Selected page persists across accesses
// (RL5) Readiness readable at offset 0xFE, any page
// (RL6) Self-clearing bit clears when operation ends
// (RL7) Sticky flags set by device, write 0 clears
// (RL8) Base configuration powers up, outputs disabled
// (RL9) Base defaults: 48 MHz crystal, 1.8 V
// (RL10) Factory image loads from NVM at power-up
// (RL11) Host may rewrite registers and burn NVM
// (RL12) Host updates shared registers read-modify-write
// (RL13) Host avoids undocumented pages and bits; the controller refuses only writes and RMW to absent pages
// (RL14) Pages 0,1,2,3,9 are implemented
// (RL15) Offset 0x01 reads back current page
// (RL16) Page select resets to page zero
`timescale 1ns/1ps
`default_nettype none
module paged_reg_bank #(
    parameter bit FACTORY_PROGRAMMED = 1'b0,
    parameter logic [7:0] FACTORY_OUT_EN = 8'hff,
    parameter logic [7:0] FACTORY_REF_CFG = 8'h03
) (
    input wire logic clk,
    input wire logic rst,
    reg_link_if.device link,
    input wire logic [5:0] statusIn,
    output logic [7:0] outEnable,
    output logic xtal48Sel,
    output logic io18Level,
    output logic ready,
    output logic [5:0] stickyFlags
);
    localparam int DEPTH = paged_reg_pkg::NUM_PAGES * 256;
    localparam logic [10:0] LAST_IDX = 11'(DEPTH - 1);

    typedef enum logic [1:0] {
        sLoad,
        sRun,
        sBurn
    } mode_t;

    // Slot of an implemented page, bit 3 set when the page is absent
    function automatic logic [3:0] pageSlot(input logic [7:0] p);
        case (p)
            paged_reg_pkg::PAGE_ALARM: pageSlot = 4'h0;
            paged_reg_pkg::PAGE_OUTPUT: pageSlot = 4'h1;
            paged_reg_pkg::PAGE_DIVIDER: pageSlot = 4'h2;
            paged_reg_pkg::PAGE_NDIV: pageSlot = 4'h3;
            paged_reg_pkg::PAGE_CTRLIO: pageSlot = 4'h4;
            default: pageSlot = 4'h8;
        endcase
    endfunction

    function automatic logic [10:0] memIndex(input logic [15:0] a);
        logic [3:0] s;
        s = pageSlot(a[15:8]);
        memIndex = {s[2:0], a[7:0]};
    endfunction

    localparam logic [10:0] IDX_OUT_EN = memIndex(paged_reg_pkg::ADDR_OUT_EN);
    localparam logic [10:0] IDX_REF_CFG = memIndex(paged_reg_pkg::ADDR_REF_CFG);

    // Power-up image held in NVM
    function automatic logic [7:0] imageByte(input logic [10:0] i);
        if (i == IDX_OUT_EN) begin
            imageByte = FACTORY_PROGRAMMED ? FACTORY_OUT_EN : paged_reg_pkg::OUT_EN_BASE;
        end else if (i == IDX_REF_CFG) begin
            imageByte = FACTORY_PROGRAMMED ? FACTORY_REF_CFG : paged_reg_pkg::REF_CFG_BASE;
        end else begin
            imageByte = 8'h00;
        end
    endfunction

    typedef logic [7:0] image_t [DEPTH];
    function automatic image_t buildImage();
        for (int i = 0; i < DEPTH; i++) begin
            buildImage[i] = imageByte(11'(i));
        end
    endfunction

    logic [7:0] vol [DEPTH];
    image_t nvm = buildImage();
    mode_t mode_q;
    logic [10:0] cnt_q;
    logic [7:0] page_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic [5:0] flags_q;
    logic [7:0] outEn_q;
    logic [7:0] refCfg_q;
    logic ready_q;

    logic take;
    logic accept;
    logic [3:0] slot;
    logic slotOk;
    logic [10:0] curIdx;
    logic onPage0;
    logic plainAccess;
    logic burnReq;
    logic [5:0] flagClr;
    logic memWe;
    logic [10:0] memIdx;
    logic [7:0] memWd;
    logic [7:0] readByte;

    assign take = link.req && !ack_q;
    // Only the readiness byte is served while the bank is loading or burning
    assign accept = take && (mode_q == sRun || link.addr == paged_reg_pkg::OFF_READY);
    assign slot = pageSlot(page_q);
    assign slotOk = !slot[3]; // RL14
    assign curIdx = {slot[2:0], link.addr}; // RL3 RL1
    assign onPage0 = page_q == paged_reg_pkg::PAGE_ALARM;
    assign plainAccess = link.addr != paged_reg_pkg::OFF_PAGE
        && link.addr != paged_reg_pkg::OFF_READY
        && !(onPage0 && (link.addr == paged_reg_pkg::OFF_STATUS
            || link.addr == paged_reg_pkg::OFF_STICKY
            || link.addr == paged_reg_pkg::OFF_BURN));
    assign burnReq = accept && link.wr && onPage0 && link.addr == paged_reg_pkg::OFF_BURN
        && link.wdata[paged_reg_pkg::BURN_BIT];
    assign flagClr = (accept && link.wr && onPage0 && link.addr == paged_reg_pkg::OFF_STICKY)
        ? ~link.wdata[5:0] & paged_reg_pkg::FLAG_MASK : 6'h00;

    // Single write port shared by the power-up load and host writes
    always_comb begin
        if (mode_q == sLoad) begin
            memWe = 1'b1;
            memIdx = cnt_q;
            memWd = nvm[cnt_q]; // RL10
        end else begin
            memWe = accept && link.wr && plainAccess && slotOk;
            memIdx = curIdx;
            memWd = link.wdata; // RL11
        end
    end

    always_comb begin
        readByte = 8'h00;
        if (link.addr == paged_reg_pkg::OFF_PAGE) begin
            readByte = page_q; // RL15
        end else if (link.addr == paged_reg_pkg::OFF_READY) begin
            readByte = ready_q ? paged_reg_pkg::READY_YES : paged_reg_pkg::READY_NO; // RL5
        end else if (onPage0 && link.addr == paged_reg_pkg::OFF_STATUS) begin
            readByte = {2'b00, sync2_q & paged_reg_pkg::FLAG_MASK};
        end else if (onPage0 && link.addr == paged_reg_pkg::OFF_STICKY) begin
            readByte = {2'b00, flags_q};
        end else if (onPage0 && link.addr == paged_reg_pkg::OFF_BURN) begin
            readByte = {7'h00, mode_q == sBurn}; // RL6
        end else if (slotOk) begin
            readByte = vol[curIdx];
        end
    end

    always_ff @(posedge clk) begin
        if (memWe) begin
            vol[memIdx] <= memWd;
        end
    end

    always_ff @(posedge clk) begin
        if (mode_q == sBurn) begin
            nvm[cnt_q] <= vol[cnt_q]; // RL11
        end
    end

    // Load at power-up, then run; a burn copies the volatile bank back
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= sLoad;
            cnt_q <= 11'h000;
        end else begin
            case (mode_q)
                sLoad: begin
                    cnt_q <= cnt_q + 11'h001;
                    if (cnt_q == LAST_IDX) begin
                        mode_q <= sRun;
                        cnt_q <= 11'h000;
                    end
                end
                sRun: begin
                    if (burnReq) begin
                        mode_q <= sBurn;
                        cnt_q <= 11'h000;
                    end
                end
                sBurn: begin
                    cnt_q <= cnt_q + 11'h001;
                    if (cnt_q == LAST_IDX) begin
                        mode_q <= sRun; // RL6
                        cnt_q <= 11'h000;
                    end
                end
                default: begin
                    mode_q <= sLoad;
                    cnt_q <= 11'h000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_q <= paged_reg_pkg::PAGE_RESET; // RL16
        end else if (accept && link.wr && link.addr == paged_reg_pkg::OFF_PAGE) begin
            page_q <= link.wdata; // RL2 RL4
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q <= accept;
            if (accept) begin
                rdata_q <= readByte;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= statusIn;
            sync2_q <= sync1_q;
        end
    end

    // Setting wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= 6'h00;
        end else begin
            flags_q <= (flags_q & ~flagClr) | (sync2_q & paged_reg_pkg::FLAG_MASK); // RL7
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outEn_q <= paged_reg_pkg::OUT_EN_BASE; // RL8
            refCfg_q <= paged_reg_pkg::REF_CFG_BASE; // RL9
        end else if (memWe) begin
            if (memIdx == IDX_OUT_EN) begin
                outEn_q <= memWd;
            end
            if (memIdx == IDX_REF_CFG) begin
                refCfg_q <= memWd;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= mode_q == sRun && !burnReq;
        end
    end

    assign link.ack = ack_q;
    assign link.rdata = rdata_q;
    assign outEnable = outEn_q;
    assign xtal48Sel = refCfg_q[paged_reg_pkg::REF_XTAL48_BIT];
    assign io18Level = refCfg_q[paged_reg_pkg::REF_IO18_BIT];
    assign ready = ready_q;
    assign stickyFlags = flags_q;
endmodule
`default_nettype wire

// file: hdl/ahb_page_controller.sv
// AHB-Lite controlled host end that issues paged byte accesses over the link
`timescale 1ns/1ps
`default_nettype none
module ahb_page_controller (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    reg_link_if.host link
);
    typedef enum logic [1:0] {
        sIdle,
        sPage,
        sRead,
        sWrite
    } state_t;

    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] hrdata_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] mask_q;
    logic opWrite_q;
    logic opRmw_q;
    logic [7:0] rdata_q;
    logic err_q;
    logic [7:0] curPage_q;
    logic pageKnown_q;
    state_t state_q;
    logic req_q;
    logic wr_q;
    logic [7:0] lAddr_q;
    logic [7:0] lData_q;
    logic [1:0] irqStat_q;
    logic [1:0] irqEn_q;
    logic irq_q;

    logic rdPhase;
    logic go;
    logic pageOk;
    logic doneEv;
    logic refuseEv;
    logic [1:0] irqClr;

    assign rdPhase = hsel && hready && htrans[1] && !hwrite;
    assign go = wrPend_q && wrAddr_q == paged_reg_pkg::HREG_CTRL
        && hwdata[paged_reg_pkg::CTRL_GO] && state_q == sIdle;
    assign pageOk = addr_q[15:8] == paged_reg_pkg::PAGE_ALARM
        || addr_q[15:8] == paged_reg_pkg::PAGE_OUTPUT
        || addr_q[15:8] == paged_reg_pkg::PAGE_DIVIDER
        || addr_q[15:8] == paged_reg_pkg::PAGE_NDIV
        || addr_q[15:8] == paged_reg_pkg::PAGE_CTRLIO;
    assign refuseEv = go && !pageOk && (hwdata[paged_reg_pkg::CTRL_WRITE]
        || hwdata[paged_reg_pkg::CTRL_RMW]); // RL13
    assign doneEv = link.ack && (state_q == sWrite || (state_q == sRead && !opRmw_q));
    assign irqClr = (wrPend_q && wrAddr_q == paged_reg_pkg::HREG_IRQ_CLEAR)
        ? hwdata[1:0] : 2'b00;

    // Address phase capture; zero wait states
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wrPend_q <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                wrAddr_q <= haddr[7:0];
            end
            if (rdPhase) begin
                case (haddr[7:0])
                    paged_reg_pkg::HREG_ADDR: hrdata_q <= {16'h0000, addr_q};
                    paged_reg_pkg::HREG_WDATA: hrdata_q <= {16'h0000, mask_q, wdata_q};
                    paged_reg_pkg::HREG_CTRL: hrdata_q <= {31'h0, state_q != sIdle};
                    paged_reg_pkg::HREG_RDATA: hrdata_q <= {23'h0, err_q, rdata_q};
                    paged_reg_pkg::HREG_IRQ_STATUS: hrdata_q <= {30'h0, irqStat_q};
                    paged_reg_pkg::HREG_IRQ_ENABLE: hrdata_q <= {30'h0, irqEn_q};
                    paged_reg_pkg::HREG_PAGE: hrdata_q <= {23'h0, pageKnown_q, curPage_q};
                    default: hrdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            mask_q <= 8'h00;
            irqEn_q <= 2'b00;
        end else if (wrPend_q && state_q == sIdle) begin
            case (wrAddr_q)
                paged_reg_pkg::HREG_ADDR: addr_q <= hwdata[15:0];
                paged_reg_pkg::HREG_WDATA: {mask_q, wdata_q} <= hwdata[15:0];
                paged_reg_pkg::HREG_IRQ_ENABLE: irqEn_q <= hwdata[1:0];
                default: addr_q <= addr_q;
            endcase
        end else if (wrPend_q && wrAddr_q == paged_reg_pkg::HREG_IRQ_ENABLE) begin
            irqEn_q <= hwdata[1:0];
        end
    end

    // Page write is skipped while the device still holds the wanted page
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= sIdle;
            opWrite_q <= 1'b0;
            opRmw_q <= 1'b0;
            rdata_q <= 8'h00;
            err_q <= 1'b0;
            curPage_q <= paged_reg_pkg::PAGE_RESET;
            pageKnown_q <= 1'b0;
            req_q <= 1'b0;
            wr_q <= 1'b0;
            lAddr_q <= 8'h00;
            lData_q <= 8'h00;
        end else begin
            case (state_q)
                sIdle: begin
                    if (go) begin
                        opWrite_q <= hwdata[paged_reg_pkg::CTRL_WRITE];
                        opRmw_q <= hwdata[paged_reg_pkg::CTRL_RMW];
                        err_q <= refuseEv;
                        if (!refuseEv) begin
                            req_q <= 1'b1;
                            if (pageKnown_q && curPage_q == addr_q[15:8]) begin // RL4
                                state_q <= hwdata[paged_reg_pkg::CTRL_WRITE]
                                    && !hwdata[paged_reg_pkg::CTRL_RMW] ? sWrite : sRead;
                                wr_q <= hwdata[paged_reg_pkg::CTRL_WRITE]
                                    && !hwdata[paged_reg_pkg::CTRL_RMW];
                                lAddr_q <= addr_q[7:0];
                                lData_q <= wdata_q;
                            end else begin
                                state_q <= sPage;
                                wr_q <= 1'b1;
                                lAddr_q <= paged_reg_pkg::OFF_PAGE; // RL2
                                lData_q <= addr_q[15:8];
                            end
                        end
                    end
                end
                sPage: begin
                    if (link.ack) begin
                        curPage_q <= addr_q[15:8]; // RL3
                        pageKnown_q <= 1'b1;
                        state_q <= opWrite_q && !opRmw_q ? sWrite : sRead;
                        wr_q <= opWrite_q && !opRmw_q;
                        lAddr_q <= addr_q[7:0];
                        lData_q <= wdata_q;
                    end
                end
                sRead: begin
                    if (link.ack) begin
                        rdata_q <= link.rdata;
                        if (opRmw_q) begin
                            state_q <= sWrite;
                            wr_q <= 1'b1;
                            lData_q <= (link.rdata & ~mask_q) | (wdata_q & mask_q); // RL12
                        end else begin
                            state_q <= sIdle;
                            req_q <= 1'b0;
                        end
                    end
                end
                sWrite: begin
                    if (link.ack) begin
                        state_q <= sIdle;
                        req_q <= 1'b0;
                        wr_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= sIdle;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStat_q <= 2'b00;
            irq_q <= 1'b0;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClr) | {refuseEv, doneEv};
            irq_q <= |(irqStat_q & irqEn_q);
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = irq_q;
    assign link.req = req_q;
    assign link.wr = wr_q;
    assign link.addr = lAddr_q;
    assign link.wdata = lData_q;
endmodule
`default_nettype wire

// file: bench/paged_register_access_asserts.sv
// Link protocol checker between the page controller and the register bank
`timescale 1ns/1ps
`default_nettype none
module paged_register_access_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    // Longest legal wait is a whole load or burn of the bank
    localparam logic [10:0] ACK_LIMIT = 11'h578;
    logic [7:0] pageQ;
    logic [10:0] waitCnt_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pageQ <= 8'h00;
        end else if (ack && wr && addr == 8'h01) begin
            pageQ <= wdata;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitCnt_q <= 11'h000;
        end else if (req && !ack) begin
            if (waitCnt_q != 11'h7ff) begin
                waitCnt_q <= waitCnt_q + 11'h001;
            end
        end else begin
            waitCnt_q <= 11'h000;
        end
    end
    sequence sPending;
        req && !ack;
    endsequence
    sequence sReadOf(logic [7:0] a);
        ack && !wr && addr == a;
    endsequence
    AST_ACK_ONE_CYCLE: assert property (ack |=> !ack)
        else $error("ack lasted more than one cycle");
    AST_ACK_HAS_REQ: assert property (ack |-> req && $past(req))
        else $error("ack without a pending request");
    AST_REQ_HELD: assert property (sPending |=> req && $stable(addr) && $stable(wdata))
        else $error("request changed before ack");
    AST_READY_ANSWER: assert property (sPending and (addr == 8'hfe) |=> ack)
        else $error("ready offset not answered next cycle");
    AST_ACK_BOUND: assert property (sPending |-> waitCnt_q < ACK_LIMIT)
        else $error("request never acknowledged");
    AST_PAGE_READBACK: assert property (sReadOf(8'h01) |-> rdata == pageQ)
        else $error("page select read back wrong");
    AST_READY_CODE: assert property (sReadOf(8'hfe) |-> rdata inside {8'h0f, 8'h00})
        else $error("bad readiness code");
    AST_RDATA_STANDS: assert property (!ack |-> $stable(rdata))
        else $error("read byte changed without ack");
endmodule
`default_nettype wire

// file: bench/paged_register_access_test.sv
// Self-checking bench joining the AHB-Lite page controller to the register bank
`timescale 1ns/1ps
`default_nettype none
module paged_register_access_test;
    logic clk;
    logic rst;
    logic hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rdv;
    logic [1:0] htrans;
    logic [5:0] statusIn;
    logic [5:0] stickyFlags;
    logic [7:0] outEnable;
    logic [7:0] pat;
    logic hreadyout;
    logic irq;
    logic xtal48Sel;
    logic io18Level;
    logic ready;
    logic [7:0] pages [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h09};
    int fails;
    int comparisons;
    reg_link_if link (.clk(clk), .rst(rst));
    ahb_page_controller u_ahb_page_controller (.clk(clk), .rst(rst), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .irq(irq),
        .link(link.host));
    paged_reg_bank u_paged_reg_bank (.clk(clk), .rst(rst), .link(link.device),
        .statusIn(statusIn), .outEnable(outEnable), .xtal48Sel(xtal48Sel),
        .io18Level(io18Level), .ready(ready), .stickyFlags(stickyFlags));
    paged_register_access_asserts u_asserts (.clk(clk), .rst(rst), .req(link.req),
        .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [7:0] rmw(logic [7:0] old, logic [7:0] d, logic [7:0] m);
        return (old & ~m) | (d & m);
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Waits for an edge with hready high; r holds hrdata as that edge saw it
    task automatic edgeReady(output logic [31:0] r);
        int n;
        logic ok;
        n = 0;
        do begin
            @(negedge clk);
            r = hrdata;
            ok = hreadyout;
            n++;
            @(posedge clk);
        end while (ok !== 1'b1 && n < 50);
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        edgeReady(r);
        htrans <= 2'b00;
        hwdata <= d;
        edgeReady(r);
    endtask
    task automatic op(logic [15:0] a, logic [7:0] d, logic [7:0] m, logic [2:0] c,
                      output logic [31:0] r);
        int n;
        bus(1'b1, paged_reg_pkg::HREG_ADDR, {16'h0, a}, r);
        bus(1'b1, paged_reg_pkg::HREG_WDATA, {16'h0, m, d}, r);
        bus(1'b1, paged_reg_pkg::HREG_CTRL, {29'h0, c | 3'b001}, r);
        n = 0;
        do begin
            bus(1'b0, paged_reg_pkg::HREG_CTRL, 32'h0, r);
            n++;
        end while (r[0] !== 1'b0 && n < 3000);
        if (r[0] !== 1'b0) begin
            fails++;
        end
        bus(1'b0, paged_reg_pkg::HREG_RDATA, 32'h0, r);
    endtask
    task automatic waitBank();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    initial begin
        fails = 0;
        comparisons = 0;
        rst = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        statusIn = 6'h00;
        void'($urandom(32'h67c0b686));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("outEnable", outEnable, 8'h00);
        check("xtal48Sel", xtal48Sel, 1'b1);
        check("io18Level", io18Level, 1'b1);
        waitBank();
        check("ready", ready, 1'b1);
        $display("test defaults finished");
        foreach (pages[i]) begin
            pat = 8'($urandom);
            op({pages[i], 8'h30}, pat, 8'hff, 3'b010, rdv);
            op({pages[i], 8'h01}, 8'h00, 8'h00, 3'b000, rdv);
            check("page", rdv[7:0], pages[i]);
            op({pages[i], 8'hfe}, 8'h00, 8'h00, 3'b000, rdv);
            check("ready code", rdv[7:0], paged_reg_pkg::READY_YES);
            op({pages[i], 8'h30}, 8'h00, 8'h00, 3'b000, rdv);
            check("scratch", rdv[7:0], pat);
        end
        pat = 8'($urandom);
        op(paged_reg_pkg::ADDR_OUT_EN, pat, 8'hff, 3'b010, rdv);
        check("outEnable", outEnable, pat);
        op(paged_reg_pkg::ADDR_REF_CFG, 8'h00, 8'h01, 3'b100, rdv);
        check("xtal48Sel", xtal48Sel, 1'b0);
        check("io18Level", io18Level, 1'b1);
        bus(1'b0, paged_reg_pkg::HREG_PAGE, 32'h0, rdv);
        check("host page", rdv, 32'h0000_0109);
        $display("test paging finished");
        bus(1'b1, paged_reg_pkg::HREG_IRQ_ENABLE, 32'h2, rdv);
        repeat (2) @(posedge clk);
        check("irq masked", irq, 1'b0);
        op(16'h0530, 8'h5a, 8'hff, 3'b010, rdv);
        check("refused", rdv[8], 1'b1);
        repeat (2) @(posedge clk);
        check("irq", irq, 1'b1);
        bus(1'b0, paged_reg_pkg::HREG_IRQ_STATUS, 32'h0, rdv);
        check("irq status", rdv, 32'h0000_0003);
        bus(1'b1, paged_reg_pkg::HREG_IRQ_CLEAR, 32'h3, rdv);
        repeat (2) @(posedge clk);
        check("irq cleared", irq, 1'b0);
        $display("test refusal finished");
        statusIn <= 6'h08;
        repeat (4) @(posedge clk);
        statusIn <= 6'h00;
        repeat (4) @(posedge clk);
        check("sticky", stickyFlags, 6'h08);
        op(16'h0011, 8'h00, 8'h08, 3'b100, rdv);
        check("sticky clear", stickyFlags, 6'(rmw(8'h08, 8'h00, 8'h08)));
        $display("test sticky finished");
        op(16'h00e3, 8'h01, 8'h01, 3'b010, rdv);
        check("ready burning", ready, 1'b0);
        op(16'h00e3, 8'h00, 8'h00, 3'b000, rdv);
        check("burn bit", rdv[7:0], 8'h00);
        waitBank();
        check("ready after burn", ready, 1'b1);
        $display("test burn finished");
        complete_run();
    end
    initial begin
        #(40 * 30000);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
